/* hw/isk_map.svh */
// Purpose: offsets, field positions and reset values of the setup key bank
// Assumes: AXI4-Lite byte addressing, 32-bit data, 16-bit registers
// Notes: register index times four gives the byte address
`ifndef ISK_MAP_SVH
`define ISK_MAP_SVH
`define ISK_IDX_STAGE_E 8'h0a
`define ISK_IDX_STAGE_C 8'h12
`define ISK_IDX_STAGE_D 8'h13
`define ISK_IDX_KEY 8'h33
`define ISK_IDX_INIT_A 8'hf4
`define ISK_IDX_INIT_B 8'hf6
`define ISK_BIT_STAGE_E 14
`define ISK_BIT_STAGE_C 6
`define ISK_BIT_STAGE_D 15
`define ISK_KEY_LO 4
`define ISK_KEY_HI 5
`define ISK_KEY_OPEN 2'h3
`define ISK_BIT_INIT 1
`define ISK_RESET_VAL 16'h0000
`define ISK_RESP_OKAY 2'h0
`define ISK_RESP_SLVERR 2'h2
`endif

/* hw/isk_pkg.sv */
// Purpose: shared types of the setup key bank
// Assumes: nothing beyond the map header
// Notes: register select is one-hot, one code per stored register
package isk_pkg;
  typedef logic [15:0] isk_word_t;
  typedef enum logic [6:0] {
    ISK_SEL_NONE = 7'h00,
    ISK_SEL_E = 7'h01,
    ISK_SEL_C = 7'h02,
    ISK_SEL_D = 7'h04,
    ISK_SEL_KEY = 7'h08,
    ISK_SEL_IA = 7'h10,
    ISK_SEL_IB = 7'h20
  } isk_sel_t;
endpackage

/* hw/isk_reg16.sv */
// Purpose: one 16-bit read/write register with byte-lane strobes
// Assumes: strobe is a single-cycle write enable
// Notes: clears to the common reset value
`include "isk_map.svh"
module isk_reg16 (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr,
  input wire logic [1:0] be,
  input wire logic [15:0] din,
  output isk_pkg::isk_word_t q
);
  import isk_pkg::*;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= `ISK_RESET_VAL;
    end else if (wr) begin
      if (be[0]) begin
        q[7:0] <= din[7:0];
      end
      if (be[1]) begin
        q[15:8] <= din[15:8];
      end
    end
  end
endmodule

/* hw/isk_bank.sv */
// Notes on behaviour
// - setup_stage_e_reg keeps the stage-E setup bit in bit 14.
// - setup_stage_c_reg keeps the stage-C setup bit in bit 6.
// - setup_stage_d_reg keeps the stage-D setup bit in bit 15.
// - All fields of the three registers read zero after reset and are R/W.
// - Key bits 5..4 of register 33h unlock init when written 11b.
// - Bit 1 of registers F4h and F6h are further init setup bits.
//
// Purpose: AXI4-Lite register bank for the initialization setup bits
// Assumes: one clock, single outstanding read and write from the master
// Notes: every register is stored whole, so reserved bits read back too
//
// The AXI4-Lite register port is this design's own decision.
`include "isk_map.svh"
module isk_bank (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic init_unlocked,
  output logic init_active,
  output logic stage_e_setup,
  output logic stage_c_setup,
  output logic stage_d_setup,
  output logic init_a_setup,
  output logic init_b_setup
);
  import isk_pkg::*;

  logic aw_held;
  logic w_held;
  logic [9:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  isk_sel_t wr_sel;
  isk_sel_t rd_sel;
  isk_word_t rd_word;
  isk_word_t q_e;
  isk_word_t q_c;
  isk_word_t q_d;
  isk_word_t q_key;
  isk_word_t q_ia;
  isk_word_t q_ib;
  logic [5:0] wr_en;
  logic bit_e;
  logic bit_c;
  logic bit_d;
  logic bit_ia;
  logic bit_ib;

  // Low two address bits ignored; word index is the register offset
  function automatic isk_sel_t decode(input logic [9:0] addr);
    unique case (addr[9:2])
      `ISK_IDX_STAGE_E: decode = ISK_SEL_E;
      `ISK_IDX_STAGE_C: decode = ISK_SEL_C;
      `ISK_IDX_STAGE_D: decode = ISK_SEL_D;
      `ISK_IDX_KEY: decode = ISK_SEL_KEY;
      `ISK_IDX_INIT_A: decode = ISK_SEL_IA;
      `ISK_IDX_INIT_B: decode = ISK_SEL_IB;
      default: decode = ISK_SEL_NONE;
    endcase
  endfunction

  // Two-bit key must match whole; a half-written key stays closed
  function automatic logic key_open(input isk_word_t w);
    key_open = (w[`ISK_KEY_HI:`ISK_KEY_LO] == `ISK_KEY_OPEN);
  endfunction

  function automatic logic bit_at(input isk_word_t w, input int pos);
    bit_at = w[pos];
  endfunction

  // Anything outside the map answers with a slave error
  function automatic logic [1:0] resp_of(input isk_sel_t sel);
    resp_of = (sel == ISK_SEL_NONE) ? `ISK_RESP_SLVERR : `ISK_RESP_OKAY;
  endfunction

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // Address and data may arrive in either order; each is held until both
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
    end
  end

  // Loads only on its own handshake, so it stands while the write waits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_addr <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_held <= 1'b0;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  assign wr_go = aw_held && w_held;
  assign wr_sel = decode(aw_addr);
  assign wr_en = wr_go ? wr_sel[5:0] : 6'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Unmapped writes are dropped but still answered, so no master hangs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bresp <= `ISK_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bresp <= resp_of(wr_sel);
    end
  end

  // Whole-word storage keeps reserved bits readable and writable
  isk_reg16 u_e (
    .clk(clk),
    .resetn(resetn),
    .wr(wr_en[0]),
    .be(w_strb[1:0]),
    .din(w_data[15:0]),
    .q(q_e)
  );

  isk_reg16 u_c (
    .clk(clk),
    .resetn(resetn),
    .wr(wr_en[1]),
    .be(w_strb[1:0]),
    .din(w_data[15:0]),
    .q(q_c)
  );

  isk_reg16 u_d (
    .clk(clk),
    .resetn(resetn),
    .wr(wr_en[2]),
    .be(w_strb[1:0]),
    .din(w_data[15:0]),
    .q(q_d)
  );

  isk_reg16 u_k (
    .clk(clk),
    .resetn(resetn),
    .wr(wr_en[3]),
    .be(w_strb[1:0]),
    .din(w_data[15:0]),
    .q(q_key)
  );

  isk_reg16 u_a (
    .clk(clk),
    .resetn(resetn),
    .wr(wr_en[4]),
    .be(w_strb[1:0]),
    .din(w_data[15:0]),
    .q(q_ia)
  );

  isk_reg16 u_b (
    .clk(clk),
    .resetn(resetn),
    .wr(wr_en[5]),
    .be(w_strb[1:0]),
    .din(w_data[15:0]),
    .q(q_ib)
  );

  assign bit_e = bit_at(q_e, `ISK_BIT_STAGE_E);
  assign bit_c = bit_at(q_c, `ISK_BIT_STAGE_C);
  assign bit_d = bit_at(q_d, `ISK_BIT_STAGE_D);
  assign bit_ia = bit_at(q_ia, `ISK_BIT_INIT);
  assign bit_ib = bit_at(q_ib, `ISK_BIT_INIT);

  // Reserved bits are not masked: software is trusted to leave them alone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_e_setup <= 1'b0;
    end else begin
      stage_e_setup <= bit_e;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_c_setup <= 1'b0;
    end else begin
      stage_c_setup <= bit_c;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_d_setup <= 1'b0;
    end else begin
      stage_d_setup <= bit_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      init_a_setup <= 1'b0;
    end else begin
      init_a_setup <= bit_ia;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      init_b_setup <= 1'b0;
    end else begin
      init_b_setup <= bit_ib;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      init_unlocked <= 1'b0;
    end else begin
      init_unlocked <= key_open(q_key);
    end
  end

  // Setup bits only raise init_active behind the open key; the setup outputs follow them regardless
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      init_active <= 1'b0;
    end else begin
      init_active <= key_open(q_key) &&
        (bit_e || bit_c || bit_d || bit_ia || bit_ib);
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel = decode(s_axi_araddr);

  always_comb begin
    rd_word = 16'h0000;
    unique case (rd_sel)
      ISK_SEL_E: rd_word = q_e;
      ISK_SEL_C: rd_word = q_c;
      ISK_SEL_D: rd_word = q_d;
      ISK_SEL_KEY: rd_word = q_key;
      ISK_SEL_IA: rd_word = q_ia;
      ISK_SEL_IB: rd_word = q_ib;
      ISK_SEL_NONE: rd_word = 16'h0000;
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Data and response load on the address handshake, then stand
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ISK_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= resp_of(rd_sel);
    end
  end
endmodule

/* tb/isk_bank_chk.sv */
// Purpose: port-level checks of the setup key bank
// Assumes: bound to isk_bank, single clock domain
// Notes: setup outputs may only move after an accepted write
module isk_bank_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic init_unlocked,
  input wire logic init_active,
  input wire logic stage_e_setup,
  input wire logic stage_c_setup,
  input wire logic stage_d_setup,
  input wire logic init_a_setup,
  input wire logic init_b_setup
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_aw_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
  chk_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  chk_rdata_high: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("rdata high");
  chk_b_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
  chk_active_and: assert property (init_active == (init_unlocked &&
    |{stage_e_setup, stage_c_setup, stage_d_setup, init_a_setup,
    init_b_setup})) else $error("init_active wrong");
  chk_setup_cause: assert property ($changed({stage_e_setup,
    stage_c_setup, stage_d_setup, init_a_setup, init_b_setup}) |->
    $past(s_axi_bvalid) && $past(s_axi_bresp) == 2'h0) else $error("setup");
  chk_key_cause: assert property ($changed(init_unlocked) |->
    $past(s_axi_bvalid) && $past(s_axi_bresp) == 2'h0) else $error("key");
endmodule
bind isk_bank isk_bank_chk u_chk (.*);

/* tb/isk_bank_tb.sv */
// Purpose: self-checking bench of the setup key bank
// Assumes: bready and rready held high by the master
// Notes: byte address is register index times four
module isk_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic init_unlocked, init_active, stage_e_setup, stage_c_setup;
  logic stage_d_setup, init_a_setup, init_b_setup;
  int fails = 0, n_tests = 0;
  logic [9:0] addr [5] = '{10'h028, 10'h048, 10'h04c, 10'h3d0, 10'h3d8};
  int pos [5] = '{14, 6, 15, 1, 1};
  wire [5:0] outs = {init_b_setup, init_a_setup, stage_d_setup,
    stage_c_setup, stage_e_setup, init_unlocked};
  isk_bank DUT (.*);
  initial forever #25 clk = ~clk;
  task automatic conclude;
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // A wait that runs out counts as a mismatch and ends the run
  task automatic give_up(input int n);
    if (n >= 40) begin
      fails++;
      conclude();
    end
  endtask
  // Handshakes are judged on values sampled at the edge, before updates
  task automatic wr(input logic [9:0] a, input logic [15:0] d,
    input logic [3:0] st, input logic [1:0] er);
    int n;
    bit aw_on;
    bit w_on;
    aw_on = 1;
    w_on = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'hffff, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (aw_on && s_axi_awready) begin
        s_axi_awvalid <= 0;
        aw_on = 0;
      end
      if (w_on && s_axi_wready) begin
        s_axi_wvalid <= 0;
        w_on = 0;
      end
      if (!aw_on && !w_on) break;
    end
    give_up(n);
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_bvalid) break;
    end
    give_up(n);
    cmp("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] ed,
    input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arready) break;
    end
    s_axi_arvalid <= 0;
    give_up(n);
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_rvalid) break;
    end
    give_up(n);
    cmp("rdata", {16'h0, ed}, s_axi_rdata);
    cmp("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  // Outputs trail the register by one edge: look mid-cycle, resume on rise
  task automatic chk_outs(input logic [5:0] e, input logic act);
    @(negedge clk);
    cmp("outs", 32'(e), 32'(outs));
    cmp("active", 32'(act), 32'(init_active));
    @(posedge clk);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rd(addr[i], 16'h0, 2'h0);
    rd(10'h0cc, 16'h0, 2'h0);
  endtask
  task automatic t_bits;
    wr(10'h0cc, 16'h0030, 4'h3, 2'h0);
    chk_outs(6'h01, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(addr[i], 16'(1 << pos[i]), 4'h3, 2'h0);
      chk_outs(6'((2 << i) | 1), 1'b1);
      rd(addr[i], 16'(1 << pos[i]), 2'h0);
      wr(addr[i], 16'h0, 4'h3, 2'h0);
      chk_outs(6'h01, 1'b0);
    end
    wr(addr[2], 16'h8000, 4'h3, 2'h0);
    wr(10'h0cc, 16'h0020, 4'h3, 2'h0);
    chk_outs(6'h08, 1'b0);
    wr(addr[2], 16'h0, 4'h3, 2'h0);
    chk_outs(6'h00, 1'b0);
  endtask
  // Reserved fields are written only with their reset value
  task automatic t_misc;
    wr(addr[0], 16'h4000, 4'h1, 2'h0);
    rd(addr[0], 16'h0000, 2'h0);
    wr(addr[0], 16'h4000, 4'h2, 2'h0);
    rd(addr[0], 16'h4000, 2'h0);
    wr(addr[1], 16'h0040, 4'h3, 2'h0);
    wr(10'h100, 16'h1234, 4'h3, 2'h2);
    rd(10'h100, 16'h0, 2'h2);
    rd(addr[1], 16'h0040, 2'h0);
    resetn <= 0;
    repeat (3) @(posedge clk);
    resetn <= 1;
    rd(addr[1], 16'h0, 2'h0);
    rd(addr[0], 16'h0, 2'h0);
    cmp("outs", 32'h0, 32'(outs));
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1;
    t_reset();
    t_bits();
    t_misc();
    conclude();
  end
endmodule
